//--- core/pfsp_consts.svh
// Constants for the program flash segment protection block.
`ifndef PFSP_CONSTS_SVH
`define PFSP_CONSTS_SVH
`define PFSP_ADDR_W 24
`define PFSP_PAGE_SHIFT 10
`define PFSP_PAGE_WORDS 1024
`define PFSP_IVT_WORDS 512
`define PFSP_MIN_PAGES_PLAIN 13'h0001
`define PFSP_MIN_PAGES_ALT 13'h0002
`define PFSP_FLASH_PAGES 13'h0040
`define PFSP_CFG_PAGES 13'h0001
`define PFSP_PAGE_CNT_W 13
`define PFSP_REG_SEC 4'h0
`define PFSP_REG_LIM 4'h1
`define PFSP_REG_STATUS 4'h2
`define PFSP_REG_LASTREQ 4'h3
`define PFSP_SEC_BOOT_WP 0
`define PFSP_SEC_BOOT_CP_LO 1
`define PFSP_SEC_BOOT_EN 3
`define PFSP_SEC_GEN_WP 4
`define PFSP_SEC_GEN_CP_LO 5
`define PFSP_SEC_CFG_WP 8
`define PFSP_SEC_CFG_CP_LO 9
`define PFSP_SEC_ALT_EN 12
`define PFSP_SEC_RESET 16'h0000
`define PFSP_LIM_RESET 16'h0001
`endif

//--- core/pfsp_pkg.sv
// Types for the program flash segment protection block.
package pfsp_pkg;
    typedef enum logic [1:0] {
        PFSP_REG_BOOT = 2'b00,
        PFSP_REG_GEN = 2'b01,
        PFSP_REG_CFG = 2'b10,
        PFSP_REG_NONE = 2'b11
    } pfsp_region_t;
    typedef enum logic [1:0] {
        PFSP_OP_FETCH = 2'b00,
        PFSP_OP_READ = 2'b01,
        PFSP_OP_PROG = 2'b10,
        PFSP_OP_ERASE = 2'b11
    } pfsp_op_t;
    typedef enum logic [1:0] {
        PFSP_ST_IDLE = 2'b00,
        PFSP_ST_GRANT = 2'b01,
        PFSP_ST_DENY = 2'b10
    } pfsp_state_t;
endpackage

//--- core/pfsp_map_if.sv
// Interface carrying segment bounds between the sizer and the checker.
`timescale 1ns/100ps
`default_nettype none
`include "pfsp_consts.svh"
interface pfsp_map_if;
    logic [`PFSP_PAGE_CNT_W-1:0] bootPages;
    logic [`PFSP_PAGE_CNT_W-1:0] altPage;
    logic [`PFSP_PAGE_CNT_W-1:0] genFirst;
    logic [`PFSP_PAGE_CNT_W-1:0] cfgFirst;
    logic bootOn;
    logic altOn;
    modport sizer (output bootPages, altPage, genFirst, cfgFirst, bootOn, altOn);
    modport user (input bootPages, altPage, genFirst, cfgFirst, bootOn, altOn);
endinterface
`default_nettype wire

//--- core/pfsp_sizer.sv
// Segment sizer: turns the page count and vector option into bounds.
`timescale 1ns/100ps
`default_nettype none
`include "pfsp_consts.svh"
module pfsp_sizer (
    input wire logic [`PFSP_PAGE_CNT_W-1:0] bootPageCount,
    input wire logic altEnable,
    input wire logic bootEnable,
    pfsp_map_if.sizer map
);
    wire logic [`PFSP_PAGE_CNT_W-1:0] minPages;
    wire logic [`PFSP_PAGE_CNT_W-1:0] clampPages;
    wire logic [`PFSP_PAGE_CNT_W-1:0] maxPages;
    assign minPages = altEnable ? `PFSP_MIN_PAGES_ALT : `PFSP_MIN_PAGES_PLAIN;
    assign maxPages = `PFSP_FLASH_PAGES - `PFSP_CFG_PAGES;
    assign clampPages = (bootPageCount < minPages) ? minPages :
        ((bootPageCount > maxPages) ? maxPages : bootPageCount);
    assign map.bootPages = bootEnable ? clampPages : '0;
    assign map.altPage = clampPages - 13'h0001;
    assign map.genFirst = map.bootPages;
    assign map.cfgFirst = maxPages;
    assign map.bootOn = bootEnable;
    assign map.altOn = altEnable & bootEnable;
endmodule // pfsp_sizer
`default_nettype wire

//--- core/pfsp_top.sv
// Program flash segment protection: access checker with register port.
// Overview of operation
// - Flash splits into boot, general, configuration regions.
// - Boot most privileged; general least.
// - Configuration region sits at top of flash.
// - Security word sets per-region protect and write-lock.
// - Boot size is page count times 1024 words.
// - Minimum boot size one page without alternate table.
// - Alternate table fills last boot page; two-page minimum.
// - Boot write-lock excludes alternate table page.
// - Boot code may always rewrite last boot page.
// - General region follows boot, up to configuration.
// - Primary table uses general security without boot.
// - Primary table locked if boot or general locked, except for boot code when boot is one page.
`timescale 1ns/100ps
`default_nettype none
`include "pfsp_consts.svh"
module pfsp_top #(
    parameter int ADDR_W = `PFSP_ADDR_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    input wire logic reqValid,
    input wire logic [ADDR_W-1:0] reqAddr,
    input wire logic [1:0] reqOp,
    input wire logic [ADDR_W-1:0] reqPc,
    output logic reqGrant,
    output logic reqDeny,
    output logic flashEn,
    output logic [ADDR_W-1:0] flashAddr,
    output logic [1:0] flashOp
);
    // ****************************************
    // Configuration words and status
    // ****************************************
    logic [15:0] securityConfigWord;
    logic [15:0] bootLimitConfigWord;
    logic [15:0] denyCount;
    logic [15:0] lastDenyPage;
    pfsp_pkg::pfsp_state_t state;
    pfsp_map_if map ();

    pfsp_sizer u_sizer (
        .bootPageCount(bootLimitConfigWord[`PFSP_PAGE_CNT_W-1:0]),
        .altEnable(securityConfigWord[`PFSP_SEC_ALT_EN]),
        .bootEnable(securityConfigWord[`PFSP_SEC_BOOT_EN]),
        .map(map)
    );

    // ****************************************
    // Region decode
    // ****************************************
    function automatic pfsp_pkg::pfsp_region_t regionOf(
        input logic [`PFSP_PAGE_CNT_W-1:0] page,
        input logic [`PFSP_PAGE_CNT_W-1:0] genFirst,
        input logic [`PFSP_PAGE_CNT_W-1:0] cfgFirst
    );
        if (page >= `PFSP_FLASH_PAGES)
            regionOf = pfsp_pkg::PFSP_REG_NONE;
        else if (page >= cfgFirst)
            regionOf = pfsp_pkg::PFSP_REG_CFG;
        else if (page < genFirst)
            regionOf = pfsp_pkg::PFSP_REG_BOOT;
        else
            regionOf = pfsp_pkg::PFSP_REG_GEN;
    endfunction

    wire logic [`PFSP_PAGE_CNT_W-1:0] tgtPage;
    wire logic [`PFSP_PAGE_CNT_W-1:0] pcPage;
    wire pfsp_pkg::pfsp_region_t tgtRegion;
    wire pfsp_pkg::pfsp_region_t pcRegion;
    assign tgtPage = `PFSP_PAGE_CNT_W'(reqAddr >> `PFSP_PAGE_SHIFT);
    assign pcPage = `PFSP_PAGE_CNT_W'(reqPc >> `PFSP_PAGE_SHIFT);
    wire logic tgtOutside;
    wire logic pcOutside;
    assign tgtOutside = (reqAddr >> `PFSP_PAGE_SHIFT) >= ADDR_W'(`PFSP_FLASH_PAGES);
    assign pcOutside = (reqPc >> `PFSP_PAGE_SHIFT) >= ADDR_W'(`PFSP_FLASH_PAGES);
    assign tgtRegion = tgtOutside ? pfsp_pkg::PFSP_REG_NONE :
        regionOf(tgtPage, map.genFirst, map.cfgFirst);
    assign pcRegion = pcOutside ? pfsp_pkg::PFSP_REG_NONE :
        regionOf(pcPage, map.genFirst, map.cfgFirst);

    wire logic bootWp;
    wire logic genWp;
    wire logic cfgWp;
    wire logic [1:0] bootCp;
    wire logic [1:0] genCp;
    wire logic [1:0] cfgCp;
    assign bootWp = securityConfigWord[`PFSP_SEC_BOOT_WP] & map.bootOn;
    assign genWp = securityConfigWord[`PFSP_SEC_GEN_WP];
    assign cfgWp = securityConfigWord[`PFSP_SEC_CFG_WP];
    assign bootCp = securityConfigWord[`PFSP_SEC_BOOT_CP_LO +: 2];
    assign genCp = securityConfigWord[`PFSP_SEC_GEN_CP_LO +: 2];
    assign cfgCp = securityConfigWord[`PFSP_SEC_CFG_CP_LO +: 2];

    wire logic isWrite;
    wire logic isPrimary;
    wire logic isAltPage;
    assign isWrite = reqOp[1];
    assign isPrimary = (reqAddr < ADDR_W'(`PFSP_IVT_WORDS));
    assign isAltPage = map.altOn && (tgtPage == map.altPage) &&
        (tgtRegion == pfsp_pkg::PFSP_REG_BOOT);

    // ****************************************
    // Write permission
    // ****************************************
    wire logic fromBoot;
    wire logic lastBootPage;
    wire logic regionLocked;
    wire logic writeOk;
    assign fromBoot = map.bootOn && (pcRegion == pfsp_pkg::PFSP_REG_BOOT);
    assign lastBootPage = map.bootOn && (tgtPage == map.altPage) &&
        (tgtRegion == pfsp_pkg::PFSP_REG_BOOT);
    assign regionLocked =
        (tgtRegion == pfsp_pkg::PFSP_REG_BOOT) ? (bootWp & ~isAltPage) :
        (tgtRegion == pfsp_pkg::PFSP_REG_GEN) ? genWp :
        (tgtRegion == pfsp_pkg::PFSP_REG_CFG) ? cfgWp : 1'b1;
    assign writeOk = (fromBoot && lastBootPage) ||
        (!(isPrimary && (bootWp || genWp)) && !regionLocked);

    // ****************************************
    // Read and fetch permission
    // ****************************************
    wire logic [1:0] tgtCp;
    wire logic [1:0] effCp;
    wire logic readOk;
    assign tgtCp = (tgtRegion == pfsp_pkg::PFSP_REG_BOOT) ? bootCp :
        (tgtRegion == pfsp_pkg::PFSP_REG_GEN) ? genCp : cfgCp;
    assign effCp = (isPrimary && !map.bootOn) ? genCp : tgtCp;
    assign readOk = (tgtRegion != pfsp_pkg::PFSP_REG_NONE) &&
        ((effCp == 2'b00) || fromBoot || (pcRegion == tgtRegion));

    wire logic allow;
    assign allow = isWrite ? writeOk : readOk;

    // ****************************************
    // Request sequencer
    // ****************************************
    pfsp_pkg::pfsp_state_t next_state;
    assign next_state = !reqValid ? pfsp_pkg::PFSP_ST_IDLE :
        (allow ? pfsp_pkg::PFSP_ST_GRANT : pfsp_pkg::PFSP_ST_DENY);

    always_ff @(posedge mclk)
    begin
        if (rst)
            state <= pfsp_pkg::PFSP_ST_IDLE;
        else
            state <= next_state;
    end

    always_comb
    begin
        case (state)
            pfsp_pkg::PFSP_ST_GRANT:
            begin
                reqGrant = 1'b1;
                reqDeny = 1'b0;
            end
            pfsp_pkg::PFSP_ST_DENY:
            begin
                reqGrant = 1'b0;
                reqDeny = 1'b1;
            end
            default:
            begin
                reqGrant = 1'b0;
                reqDeny = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            flashEn <= 1'b0;
            flashAddr <= '0;
            flashOp <= 2'h0;
        end
        else
        begin
            flashEn <= reqValid && allow;
            flashAddr <= reqAddr;
            flashOp <= reqOp;
        end
    end

    // ****************************************
    // Register port
    // ****************************************
    wire logic denyEvent;
    assign denyEvent = reqValid && !allow;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            securityConfigWord <= `PFSP_SEC_RESET;
            bootLimitConfigWord <= `PFSP_LIM_RESET;
        end
        else if (regWr && regAddr == `PFSP_REG_SEC)
            securityConfigWord <= regWdata;
        else if (regWr && regAddr == `PFSP_REG_LIM)
            bootLimitConfigWord <= regWdata;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            denyCount <= 16'h0000;
            lastDenyPage <= 16'h0000;
        end
        else if (denyEvent)
        begin
            denyCount <= denyCount + 16'h0001;
            lastDenyPage <= {3'h0, tgtPage};
        end
        else if (regWr && regAddr == `PFSP_REG_STATUS)
            denyCount <= 16'h0000;
    end

    wire logic [15:0] rdMux;
    assign rdMux = (regAddr == `PFSP_REG_SEC) ? securityConfigWord :
        (regAddr == `PFSP_REG_LIM) ? bootLimitConfigWord :
        (regAddr == `PFSP_REG_STATUS) ? denyCount :
        (regAddr == `PFSP_REG_LASTREQ) ? lastDenyPage : 16'h0000;

    always_ff @(posedge mclk)
    begin
        if (rst)
            regRdata <= 16'h0000;
        else
            regRdata <= regRd ? rdMux : 16'h0000;
    end

    // ****************************************
    // Checks
    // ****************************************
    primary_lock_a: assert property (@(posedge mclk) disable iff (rst)
        (reqValid && isWrite && isPrimary && (bootWp || genWp) && !(fromBoot && lastBootPage))
        |=> reqDeny && !flashEn)
        else $error("Primary table write passed while locked.");
    refused_write_a: assert property (@(posedge mclk) disable iff (rst)
        reqDeny |-> !flashEn)
        else $error("Refused request reached the flash.");
    last_page_a: assert property (@(posedge mclk) disable iff (rst)
        (reqValid && isWrite && fromBoot && lastBootPage) |=> reqGrant && flashEn)
        else $error("Boot code could not rewrite last boot page.");
    alt_min_a: assert property (@(posedge mclk) disable iff (rst)
        (map.altOn) |-> (map.genFirst >= 13'h0002))
        else $error("Boot region below two pages with alternate table.");
    boot_min_a: assert property (@(posedge mclk) disable iff (rst)
        (map.bootOn) |-> (map.genFirst >= 13'h0001))
        else $error("Boot region below one page.");
    alt_unlocked_a: assert property (@(posedge mclk) disable iff (rst)
        (reqValid && isWrite && isAltPage && !genWp && !isPrimary) |=> reqGrant)
        else $error("Alternate table page blocked by boot lock.");
    gen_lock_a: assert property (@(posedge mclk) disable iff (rst)
        (reqValid && isWrite && tgtRegion == pfsp_pkg::PFSP_REG_GEN && genWp)
        |=> reqDeny)
        else $error("General region write passed while locked.");
    cfg_top_a: assert property (@(posedge mclk) disable iff (rst)
        (reqValid && !tgtOutside && tgtPage == `PFSP_FLASH_PAGES - 13'h0001)
        |-> tgtRegion == pfsp_pkg::PFSP_REG_CFG)
        else $error("Top page not in configuration region.");
    grant_one_a: assert property (@(posedge mclk) disable iff (rst)
        !reqValid |=> !reqGrant && !reqDeny)
        else $error("Answer without request.");

    // ****************************************
    // Region and count checks
    // ****************************************
    region_three_a: assert property (@(posedge mclk) disable iff (rst)
        (!tgtOutside && tgtPage < `PFSP_FLASH_PAGES)
        |-> (tgtRegion != pfsp_pkg::PFSP_REG_NONE))
        else $error("In-flash page mapped to no region.");
    outside_deny_a: assert property (@(posedge mclk) disable iff (rst)
        (reqValid && tgtRegion == pfsp_pkg::PFSP_REG_NONE)
        |=> reqDeny && !flashEn)
        else $error("Access beyond flash was granted.");
    boot_read_a: assert property (@(posedge mclk) disable iff (rst)
        (reqValid && !isWrite && fromBoot && tgtRegion != pfsp_pkg::PFSP_REG_NONE)
        |=> reqGrant)
        else $error("Boot code refused a read.");
    gen_guard_a: assert property (@(posedge mclk) disable iff (rst)
        (reqValid && !isWrite && tgtRegion == pfsp_pkg::PFSP_REG_BOOT && bootCp != 2'b00 &&
        pcRegion == pfsp_pkg::PFSP_REG_GEN) |=> reqDeny)
        else $error("General code read protected boot page.");
    cfg_lock_a: assert property (@(posedge mclk) disable iff (rst)
        (reqValid && isWrite && tgtRegion == pfsp_pkg::PFSP_REG_CFG && cfgWp)
        |=> reqDeny)
        else $error("Configuration write passed while locked.");
    boot_lock_a: assert property (@(posedge mclk) disable iff (rst)
        (reqValid && isWrite && tgtRegion == pfsp_pkg::PFSP_REG_BOOT && bootWp && !lastBootPage)
        |=> reqDeny)
        else $error("Boot region write passed while locked.");
    boot_size_a: assert property (@(posedge mclk) disable iff (rst)
        (map.bootOn && bootLimitConfigWord[12:0] >= 13'h0002 &&
        bootLimitConfigWord[12:0] < 13'h003F) |-> (map.genFirst == bootLimitConfigWord[12:0]))
        else $error("Boot size differs from page count.");
    boot_off_a: assert property (@(posedge mclk) disable iff (rst)
        !map.bootOn
        |-> (map.genFirst == 13'h0000))
        else $error("General region does not start at page zero.");
    gen_span_a: assert property (@(posedge mclk) disable iff (rst)
        (reqValid && tgtPage >= map.genFirst && tgtPage < map.cfgFirst && !tgtOutside)
        |-> (tgtRegion == pfsp_pkg::PFSP_REG_GEN))
        else $error("Page between boot and configuration not general.");
    gen_after_a: assert property (@(posedge mclk) disable iff (rst)
        (reqValid && map.bootOn && !tgtOutside && tgtPage == map.genFirst - 13'h0001)
        |-> (tgtRegion == pfsp_pkg::PFSP_REG_BOOT))
        else $error("Page before general region not boot.");
    alt_page_a: assert property (@(posedge mclk) disable iff (rst)
        map.altOn
        |-> (map.altPage == map.genFirst - 13'h0001))
        else $error("Alternate table not on last boot page.");
    primary_share_a: assert property (@(posedge mclk) disable iff (rst)
        (reqValid && !isWrite && isPrimary && !map.bootOn && genCp != 2'b00 &&
        pcRegion != pfsp_pkg::PFSP_REG_GEN) |=> reqDeny)
        else $error("Primary table ignored general read protection.");
    primary_boot_a: assert property (@(posedge mclk) disable iff (rst)
        (reqValid && !isWrite && isPrimary && map.bootOn && bootCp == 2'b00)
        |=> reqGrant)
        else $error("Primary table did not follow open boot level.");
    flash_grant_a: assert property (@(posedge mclk) disable iff (rst)
        flashEn
        |-> reqGrant)
        else $error("Flash enabled without a grant.");
    answer_once_a: assert property (@(posedge mclk) disable iff (rst)
        reqValid
        |=> (reqGrant ^ reqDeny))
        else $error("Request not answered exactly once.");
    deny_count_a: assert property (@(posedge mclk) disable iff (rst)
        (reqValid && !allow)
        |=> (denyCount == $past(denyCount) + 16'h0001))
        else $error("Refusal not counted.");
endmodule // pfsp_top
`default_nettype wire

//--- bench/pfsp_flash_model.sv
// Flash array model that counts program and erase operations per page.
`timescale 1ns/100ps
`default_nettype none
module pfsp_flash_model (
    input wire logic mclk,
    input wire logic flashEn,
    input wire logic [23:0] flashAddr,
    input wire logic [1:0] flashOp
);
    int writes [0:127];
    initial
    begin
        for (int i = 0; i < 128; i++)
        begin
            writes[i] = 0;
        end
    end
    // The array changes only on an operation the checker let through.
    always @(posedge mclk)
    begin
        if (flashEn && flashOp[1])
        begin
            writes[flashAddr[16:10]] <= writes[flashAddr[16:10]] + 1;
        end
    end
endmodule // pfsp_flash_model
`default_nettype wire

//--- bench/pfsp_top_bench.sv
// Self-checking bench for the program flash segment protection block.
`timescale 1ns/100ps
`default_nettype none
module pfsp_top_bench;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic mclk, rst, regWr, regRd, reqValid, reqGrant, reqDeny, flashEn;
    logic [3:0] regAddr;
    logic [15:0] regWdata, regRdata;
    logic [23:0] reqAddr, reqPc, flashAddr;
    logic [1:0] reqOp, flashOp;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    pfsp_top i_dut (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .reqValid(reqValid),
        .reqAddr(reqAddr), .reqOp(reqOp), .reqPc(reqPc), .reqGrant(reqGrant),
        .reqDeny(reqDeny), .flashEn(flashEn), .flashAddr(flashAddr), .flashOp(flashOp));
    pfsp_flash_model i_flash (.mclk(mclk), .flashEn(flashEn), .flashAddr(flashAddr),
        .flashOp(flashOp));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
            err_total++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        check("regRdata", exp, regRdata);
    endtask
    task automatic acc(input logic [12:0] pg, input logic [9:0] off, input logic [1:0] op,
        input logic [12:0] pcPg, input logic expG);
        int w0;
        w0 = i_flash.writes[pg[6:0]];
        @(posedge mclk);
        reqValid <= 1'b1;
        reqAddr <= {1'b0, pg, off};
        reqOp <= op;
        reqPc <= {1'b0, pcPg, 10'h000};
        @(posedge mclk);
        reqValid <= 1'b0;
        #1;
        check("reqGrant", expG, reqGrant);
        check("reqDeny", !expG, reqDeny);
        check("flashEn", expG, flashEn);
        if (expG)
        begin
            check("flashAddr", {1'b0, pg, off}, flashAddr);
            check("flashOp", op, flashOp);
        end
        @(posedge mclk);
        #1;
        check("flashWrites", w0 + (expG & op[1]), i_flash.writes[pg[6:0]]);
    endtask
    task automatic close_out;
        $display("Mismatches %0d of %0d comparisons", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
        begin
            $display("Regression OK");
        end
        else
        begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        rd(4'h0, 16'h0000);
        rd(4'h1, 16'h0001);
        rd(4'h5, 16'h0000);
        $display("t_reset done");
    endtask
    task automatic t_boot_lock;
        wr(4'h0, 16'h0009);
        wr(4'h1, 16'h0004);
        acc(13'h0001, 10'h000, pfsp_pkg::PFSP_OP_PROG, 13'h000A, 1'b0);
        acc(13'h0003, 10'h3FF, pfsp_pkg::PFSP_OP_ERASE, 13'h000A, 1'b0);
        acc(13'h0004, 10'h000, pfsp_pkg::PFSP_OP_PROG, 13'h000A, 1'b1);
        acc(13'h0001, 10'h000, pfsp_pkg::PFSP_OP_READ, 13'h000A, 1'b1);
        rd(4'h2, 16'h0002);
        rd(4'h3, 16'h0003);
        $display("t_boot_lock done");
    endtask
    task automatic t_alt_table;
        wr(4'h0, 16'h1009);
        acc(13'h0003, 10'h000, pfsp_pkg::PFSP_OP_PROG, 13'h000A, 1'b1);
        acc(13'h0002, 10'h000, pfsp_pkg::PFSP_OP_PROG, 13'h000A, 1'b0);
        wr(4'h1, 16'h0001);
        acc(13'h0001, 10'h000, pfsp_pkg::PFSP_OP_ERASE, 13'h000A, 1'b1);
        acc(13'h0000, 10'h200, pfsp_pkg::PFSP_OP_PROG, 13'h000A, 1'b0);
        wr(4'h0, 16'h0009);
        wr(4'h1, 16'h0000);
        acc(13'h0000, 10'h200, pfsp_pkg::PFSP_OP_PROG, 13'h000A, 1'b0);
        acc(13'h0001, 10'h000, pfsp_pkg::PFSP_OP_PROG, 13'h000A, 1'b1);
        $display("t_alt_table done");
    endtask
    task automatic t_last_page;
        wr(4'h0, 16'h0019);
        wr(4'h1, 16'h0004);
        acc(13'h0003, 10'h010, pfsp_pkg::PFSP_OP_ERASE, 13'h0000, 1'b1);
        acc(13'h0003, 10'h010, pfsp_pkg::PFSP_OP_PROG, 13'h000A, 1'b0);
        acc(13'h0008, 10'h000, pfsp_pkg::PFSP_OP_PROG, 13'h0001, 1'b0);
        $display("t_last_page done");
    endtask
    task automatic t_vector_table;
        wr(4'h0, 16'h0018);
        acc(13'h0000, 10'h100, pfsp_pkg::PFSP_OP_PROG, 13'h0001, 1'b0);
        acc(13'h0000, 10'h300, pfsp_pkg::PFSP_OP_PROG, 13'h0001, 1'b1);
        wr(4'h0, 16'h0020);
        acc(13'h0000, 10'h100, pfsp_pkg::PFSP_OP_READ, 13'h003F, 1'b0);
        wr(4'h0, 16'h0028);
        acc(13'h0000, 10'h100, pfsp_pkg::PFSP_OP_READ, 13'h003F, 1'b1);
        $display("t_vector_table done");
    endtask
    task automatic t_config;
        wr(4'h0, 16'h0100);
        acc(13'h003F, 10'h000, pfsp_pkg::PFSP_OP_PROG, 13'h000A, 1'b0);
        acc(13'h003E, 10'h3FF, pfsp_pkg::PFSP_OP_PROG, 13'h000A, 1'b1);
        acc(13'h0040, 10'h000, pfsp_pkg::PFSP_OP_FETCH, 13'h000A, 1'b0);
        wr(4'h2, 16'h0000);
        rd(4'h2, 16'h0000);
        $display("t_config done");
    endtask
    // ****************************************
    // Clock, timeout and main sequence
    // ****************************************
    initial
    begin
        mclk = 1'b0;
        forever
        begin
            #10 mclk = ~mclk;
        end
    end
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            err_total++;
            close_out();
        end
    end
    initial
    begin
        rst = 1'b1;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 4'h0;
        regWdata = 16'h0000;
        reqValid = 1'b0;
        reqAddr = 24'h000000;
        reqOp = 2'h0;
        reqPc = 24'h000000;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_boot_lock();
        t_alt_table();
        t_last_page();
        t_vector_table();
        t_config();
        close_out();
    end
endmodule // pfsp_top_bench
`default_nettype wire
